// ===== design/pixel_window_gain_offset.sv
// Summary of operation
// - window origin is column 0, row 0
// - window set by left, width, top, height
// - forward inside pixels, drop all others
// - window only with format 7, mode 0
// - gain accepted 192..768 mono, 192..640 colour
// - gain 192 is unity and default
// - unity gain keeps black and full scale
// - gain 374 doubles, 499 quadruples
// - brightness accepts 0..255
// - normal depths: offset is brightness over 16
// - sixteen-bit: offset equals brightness
`timescale 1ns/1ps
`include "pwgo_defs.svh"

module pixel_window_gain_offset
    import pixel_window_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire logic              pix_valid,
    input  wire logic [`PIX_W-1:0] pix_data,
    input  wire logic              pix_sof,
    input  wire logic              pix_eol,
    output logic                   pix_ready,
    output logic                   out_valid,
    output logic      [`PIX_W-1:0] out_data,
    input  wire logic              out_ready,
    output logic                   window_active
);

    // ********
    // declarations
    // ********

    core_state_t          q;
    core_state_t          d;
    logic                 take;
    logic [`COORD_W-1:0]  cur_col;
    logic [`COORD_W-1:0]  cur_row;
    logic [`COORD_W:0]    col_end;
    logic [`COORD_W:0]    row_end;
    logic                 in_win;
    logic [`PIX_W-1:0]    full_scale;
    logic [`PIX_W-1:0]    pix_in;
    logic [27:0]          product;
    logic [19:0]          scaled;
    logic [7:0]           offset;
    logic [20:0]          summed;
    logic [`PIX_W-1:0]    result;
    logic [`GAIN_W-1:0]   gain_max;
    logic [`GAIN_W-1:0]   wr_gain;

    pix_stream_if to_buf ();
    pix_stream_if from_buf ();

    // ****************************************************************
    // gain curve
    // ****************************************************************

    // piecewise line through the x1/x2/x4/x7.5 points, factor x256;
    // avoids a divider on the pixel clock at the cost of a small error
    function automatic logic [`FACTOR_W-1:0] gain_factor(input logic [`GAIN_W-1:0] dn);
        logic [`GAIN_W-1:0]   diff;
        logic [`FACTOR_W-1:0] base;
        logic [`FACTOR_W-1:0] slope;
        logic [19:0]          step;
        diff  = '0;
        base  = `GAIN_F_X1;
        slope = `GAIN_SLOPE_1;
        if (dn < `GAIN_DN_X2) begin
            diff  = dn - `GAIN_DN_X1;
            base  = `GAIN_F_X1;
            slope = `GAIN_SLOPE_1;
        end else if (dn < `GAIN_DN_X4) begin
            diff  = dn - `GAIN_DN_X2;
            base  = `GAIN_F_X2;
            slope = `GAIN_SLOPE_2;
        end else if (dn < `GAIN_DN_X7) begin
            diff  = dn - `GAIN_DN_X4;
            base  = `GAIN_F_X4;
            slope = `GAIN_SLOPE_3;
        end else begin
            diff  = dn - `GAIN_DN_X7;
            base  = `GAIN_F_X7;
            slope = `GAIN_SLOPE_4;
        end
        step = 20'(diff[7:0] * slope);
        return `FACTOR_W'(base + step[19:8]);
    endfunction

    // ********
    // position tracking and window test
    // ********

    // a pixel is consumed whenever the buffer can take one, inside or not
    assign take = pix_valid && to_buf.ready;

    // frame start forces the pixel to the top-left corner
    always_comb begin
        cur_col = pix_sof ? '0 : q.col;
        cur_row = pix_sof ? '0 : q.row;
    end

    // one extra bit keeps left plus width from wrapping
    always_comb begin
        col_end = {1'b0, q.win_left} + {1'b0, q.win_width};
        row_end = {1'b0, q.win_top} + {1'b0, q.win_height};
        in_win  = !q.win_active
            || ({1'b0, cur_col} >= {1'b0, q.win_left} && {1'b0, cur_col} < col_end
             && {1'b0, cur_row} >= {1'b0, q.win_top} && {1'b0, cur_row} < row_end);
    end

    // ****************************************************************
    // gain and offset on the pixel value
    // ****************************************************************

    // full scale and input masking follow the output depth
    always_comb begin
        case (q.depth)
            DEPTH_8: begin
                full_scale = `FULL_8;
            end
            DEPTH_12: begin
                full_scale = `FULL_12;
            end
            default: begin
                full_scale = `FULL_16;
            end
        endcase
        pix_in = pix_data & full_scale;
    end

    // unity factor leaves black at 0 and white at full scale
    always_comb begin
        product = 28'(pix_in * q.factor);
        scaled  = product[27:8];
        if (q.depth == DEPTH_16) begin
            offset = q.brightness;
        end else begin
            offset = {4'h0, q.brightness[7:4]};
        end
        summed = {1'b0, scaled} + {13'h0000, offset};
        // clip instead of wrapping so bright pixels never turn dark
        if (summed > {5'h00, full_scale}) begin
            result = full_scale;
        end else begin
            result = summed[`PIX_W-1:0];
        end
    end

    // only window pixels enter the buffer
    assign to_buf.valid = pix_valid && in_win;
    assign to_buf.data  = result;

    // ****************************************************************
    // settings writes, read back and tracking state
    // ****************************************************************

    // widest legal gain depends on the sensor variant
    always_comb begin
        gain_max = q.colour ? `GAIN_MAX_COLOUR : `GAIN_MAX_MONO;
        wr_gain  = reg_wdata[`GAIN_W-1:0];
    end

    always_comb begin
        d = q;
        // position counters advance per consumed pixel
        if (take) begin
            if (pix_eol) begin
                d.col = '0;
                d.row = cur_row + 1'b1;
            end else begin
                d.col = cur_col + 1'b1;
                d.row = cur_row;
            end
        end
        // software writes
        if (reg_wr) begin
            case (reg_addr)
                `REG_VIDEO_FORMAT: begin
                    d.video_format = reg_wdata[3:0];
                end
                `REG_VIDEO_MODE: begin
                    d.video_mode = reg_wdata[2:0];
                end
                `REG_WIN_LEFT: begin
                    d.win_left = reg_wdata[`COORD_W-1:0];
                end
                `REG_WIN_TOP: begin
                    d.win_top = reg_wdata[`COORD_W-1:0];
                end
                `REG_WIN_WIDTH: begin
                    d.win_width = reg_wdata[`COORD_W-1:0];
                end
                `REG_WIN_HEIGHT: begin
                    d.win_height = reg_wdata[`COORD_W-1:0];
                end
                `REG_GAIN: begin
                    // out-of-range or upper-bit values keep the old gain
                    if (reg_wdata[31:`GAIN_W] == '0 && wr_gain >= `GAIN_MIN
                        && wr_gain <= gain_max) begin
                        d.gain = wr_gain;
                    end else begin
                        d.gain_err = 1'b1;
                    end
                end
                `REG_BRIGHTNESS: begin
                    d.brightness = reg_wdata[7:0];
                end
                `REG_OUT_CONFIG: begin
                    d.colour = reg_wdata[`CFG_COLOUR_BIT];
                    d.depth  = depth_t'(reg_wdata[`CFG_DEPTH_LSB +: 2]);
                end
                `REG_STATUS: begin
                    if (reg_wdata[`STAT_GAIN_ERR_BIT]) begin
                        d.gain_err = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // registered so the long compare stays off the pixel path
        d.win_active = (q.video_format == `WIN_FORMAT)
                    && (q.video_mode == `WIN_MODE);
        d.factor     = gain_factor(q.gain);
        // read data stands for the one cycle after the strobe
        d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `REG_VIDEO_FORMAT: begin
                    d.rdata = {28'h0000000, q.video_format};
                end
                `REG_VIDEO_MODE: begin
                    d.rdata = {29'h00000000, q.video_mode};
                end
                `REG_WIN_LEFT: begin
                    d.rdata = {22'h000000, q.win_left};
                end
                `REG_WIN_TOP: begin
                    d.rdata = {22'h000000, q.win_top};
                end
                `REG_WIN_WIDTH: begin
                    d.rdata = {22'h000000, q.win_width};
                end
                `REG_WIN_HEIGHT: begin
                    d.rdata = {22'h000000, q.win_height};
                end
                `REG_GAIN: begin
                    d.rdata = {22'h000000, q.gain};
                end
                `REG_BRIGHTNESS: begin
                    d.rdata = {24'h000000, q.brightness};
                end
                `REG_OUT_CONFIG: begin
                    d.rdata = {29'h00000000, q.depth, q.colour};
                end
                `REG_STATUS: begin
                    d.rdata = {30'h00000000, q.gain_err, q.win_active};
                end
                `REG_POSITION: begin
                    d.rdata = {6'h00, q.row, 6'h00, q.col};
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    // ********
    // state register
    // ********

    always_ff @(posedge clk) begin
        if (srst) begin
            q              <= '0;
            q.video_format <= `RST_VIDEO_FORMAT;
            q.video_mode   <= `RST_VIDEO_MODE;
            q.win_left     <= `RST_WIN_LEFT;
            q.win_top      <= `RST_WIN_TOP;
            q.win_width    <= `RST_WIN_WIDTH;
            q.win_height   <= `RST_WIN_HEIGHT;
            q.gain         <= `RST_GAIN;
            q.brightness   <= `RST_BRIGHTNESS;
            q.depth        <= DEPTH_8;
            q.factor       <= `GAIN_F_X1;
        end else begin
            q <= d;
        end
    end

    // ********
    // output buffer and port hookup
    // ********

    pix_skid_buffer u_buf (
        .clk   (clk),
        .srst  (srst),
        .fill  (to_buf),
        .drain (from_buf)
    );

    assign from_buf.ready = out_ready;
    assign pix_ready      = to_buf.ready;
    assign out_valid      = from_buf.valid;
    assign out_data       = from_buf.data;
    assign reg_rdata      = q.rdata;
    assign window_active  = q.win_active;

endmodule

// ===== common/pwgo_defs.svh
`ifndef PWGO_DEFS_SVH
`define PWGO_DEFS_SVH

// ********
// register word offsets on the plain register port
// ********
`define REG_VIDEO_FORMAT   4'h0
`define REG_VIDEO_MODE     4'h1
`define REG_WIN_LEFT       4'h2
`define REG_WIN_TOP        4'h3
`define REG_WIN_WIDTH      4'h4
`define REG_WIN_HEIGHT     4'h5
`define REG_GAIN           4'h6
`define REG_BRIGHTNESS     4'h7
`define REG_OUT_CONFIG     4'h8
`define REG_STATUS         4'h9
`define REG_POSITION       4'hA

// ********
// field positions
// ********
`define CFG_COLOUR_BIT     0
`define CFG_DEPTH_LSB      1
`define STAT_WIN_BIT       0
`define STAT_GAIN_ERR_BIT  1
`define POS_ROW_LSB        16

// ********
// widths
// ********
`define PIX_W              16
`define COORD_W            10
`define GAIN_W             10
`define FACTOR_W           12

// ********
// reset values
// ********
`define RST_VIDEO_FORMAT   4'h0
`define RST_VIDEO_MODE     3'h0
`define RST_WIN_LEFT       10'h000
`define RST_WIN_TOP        10'h000
`define RST_WIN_WIDTH      10'h293
`define RST_WIN_HEIGHT     10'h1EE
`define RST_GAIN           10'h0C0
`define RST_BRIGHTNESS     8'h08

// ********
// windowing selection and gain limits
// ********
`define WIN_FORMAT         4'h7
`define WIN_MODE           3'h0
`define GAIN_MIN           10'h0C0
`define GAIN_MAX_MONO      10'h300
`define GAIN_MAX_COLOUR    10'h280

// ********
// gain curve break points (dn) and factors (x256)
// ********
`define GAIN_DN_X1         10'h0C0
`define GAIN_DN_X2         10'h176
`define GAIN_DN_X4         10'h1F3
`define GAIN_DN_X7         10'h280
`define GAIN_F_X1          12'h100
`define GAIN_F_X2          12'h200
`define GAIN_F_X4          12'h400
`define GAIN_F_X7          12'h780
`define GAIN_SLOPE_1       12'h168
`define GAIN_SLOPE_2       12'h419
`define GAIN_SLOPE_3       12'h65B
`define GAIN_SLOPE_4       12'hA34

// ********
// full scale per output depth
// ********
`define FULL_8             16'h00FF
`define FULL_12            16'h0FFF
`define FULL_16            16'hFFFF

`endif

// ===== common/pixel_window_pkg.sv
package pixel_window_pkg;
`include "pwgo_defs.svh"

    // output sample depth
    typedef enum logic [1:0] {
        DEPTH_8  = 2'h0,
        DEPTH_12 = 2'h1,
        DEPTH_16 = 2'h3
    } depth_t;

    // two-entry buffer state
    typedef struct packed {
        logic              head_valid;
        logic [`PIX_W-1:0] head_data;
        logic              tail_valid;
        logic [`PIX_W-1:0] tail_data;
    } buf_state_t;

    // settings, position tracking and read data of the core
    typedef struct packed {
        logic [3:0]           video_format;
        logic [2:0]           video_mode;
        logic [`COORD_W-1:0]  win_left;
        logic [`COORD_W-1:0]  win_top;
        logic [`COORD_W-1:0]  win_width;
        logic [`COORD_W-1:0]  win_height;
        logic [`GAIN_W-1:0]   gain;
        logic [7:0]           brightness;
        logic                 colour;
        depth_t               depth;
        logic                 gain_err;
        logic [`COORD_W-1:0]  col;
        logic [`COORD_W-1:0]  row;
        logic [`FACTOR_W-1:0] factor;
        logic                 win_active;
        logic [31:0]          rdata;
    } core_state_t;

endpackage

// ===== common/pix_stream_if.sv
`timescale 1ns/1ps
`include "pwgo_defs.svh"

// valid/ready word stream between the core and its buffer
interface pix_stream_if;
    logic              valid;
    logic              ready;
    logic [`PIX_W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== design/pix_skid_buffer.sv
`timescale 1ns/1ps
`include "pwgo_defs.svh"

// two-entry buffer; ready and valid come straight from flops
module pix_skid_buffer
    import pixel_window_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    pix_stream_if.snk fill,
    pix_stream_if.src drain
);

    buf_state_t q;
    buf_state_t d;
    logic       push;
    logic       pop;

    // ********
    // next state
    // ********

    // tail entry absorbs a word while the drain side stalls
    always_comb begin
        d    = q;
        pop  = q.head_valid && drain.ready;
        push = fill.valid && !q.tail_valid;
        if (pop) begin
            d.head_valid = q.tail_valid;
            d.head_data  = q.tail_data;
            d.tail_valid = 1'b0;
        end
        if (push) begin
            if (!d.head_valid) begin
                d.head_valid = 1'b1;
                d.head_data  = fill.data;
            end else begin
                d.tail_valid = 1'b1;
                d.tail_data  = fill.data;
            end
        end
    end

    // ********
    // registers
    // ********

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // full only when the tail is taken: honest back-pressure
    assign fill.ready  = !q.tail_valid;
    assign drain.valid = q.head_valid;
    assign drain.data  = q.head_data;

endmodule

// ===== verif/pwgo_props.sv
`timescale 1ns/1ps
`include "pwgo_defs.svh"

// ********
// port checks of the window, gain and offset block
// ********
module pwgo_props (
    input wire logic              clk,
    input wire logic              srst,
    input wire logic [3:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic              pix_valid,
    input wire logic [`PIX_W-1:0] pix_data,
    input wire logic              pix_sof,
    input wire logic              pix_eol,
    input wire logic              pix_ready,
    input wire logic              out_valid,
    input wire logic [`PIX_W-1:0] out_data,
    input wire logic              out_ready,
    input wire logic              window_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // a stalled word must stay put, or the frame buffer loses it
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
    a_hold: assert property (p_hold)
        else $error("output word changed while stalled");
    property p_full; !pix_ready |-> out_valid; endproperty
    a_full: assert property (p_full)
        else $error("input refused with nothing to deliver");
    property p_rise; $rose(out_valid) |-> $past(pix_valid && pix_ready); endproperty
    a_rise: assert property (p_rise)
        else $error("output word without a taken pixel");
    // format lands at the write edge, the registered flag one edge later
    property p_win_off;
        reg_wr && reg_addr == `REG_VIDEO_FORMAT && reg_wdata[3:0] != 4'h7 |-> ##2 !window_active;
    endproperty
    a_win_off: assert property (p_win_off)
        else $error("window active with another format");
    // only a register write may move the window selection
    property p_win_keep; !$past(reg_wr, 2) |-> $stable(window_active); endproperty
    a_win_keep: assert property (p_win_keep)
        else $error("window selection moved without a write");
    property p_stat;
        $past(reg_rd) && $past(reg_addr) == `REG_STATUS
            |-> reg_rdata[31:2] == 30'h0 && reg_rdata[0] == $past(window_active);
    endproperty
    a_stat: assert property (p_stat)
        else $error("status read disagrees with window flag");
    property p_gain_err;
        reg_wr && reg_addr == `REG_GAIN && reg_wdata < 32'h000000C0
            ##2 reg_rd && reg_addr == `REG_STATUS |=> reg_rdata[1];
    endproperty
    a_gain_err: assert property (p_gain_err)
        else $error("gain below range not flagged");
    property p_bright;
        $past(reg_rd) && $past(reg_addr) == `REG_BRIGHTNESS |-> reg_rdata[31:8] == 24'h0;
    endproperty
    a_bright: assert property (p_bright)
        else $error("brightness wider than eight bits");
    property p_pos;
        $past(reg_rd) && $past(reg_addr) == `REG_POSITION
            |-> reg_rdata[31:26] == 6'h0 && reg_rdata[15:10] == 6'h0;
    endproperty
    a_pos: assert property (p_pos)
        else $error("position read has stray bits");

    c_backpressure: cover property (!pix_ready);
    c_window_out: cover property (window_active && out_valid && out_ready);
    c_refused: cover property (reg_wr && reg_addr == `REG_GAIN ##2 reg_rd ##1 reg_rdata[1]);
endmodule

bind pixel_window_gain_offset pwgo_props props_u (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_sof(pix_sof), .pix_eol(pix_eol),
    .pix_ready(pix_ready), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .window_active(window_active)
);

// ===== verif/pix_partner.sv
`timescale 1ns/1ps
`include "pwgo_defs.svh"

// ********
// sensor readout source and frame buffer sink
// ********
module pix_partner (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              pix_ready,
    input  wire logic              out_valid,
    input  wire logic [`PIX_W-1:0] out_data,
    output logic                   pix_valid,
    output logic      [`PIX_W-1:0] pix_data,
    output logic                   pix_sof,
    output logic                   pix_eol,
    output logic                   out_ready
);
    logic [`PIX_W-1:0] got_q[$];
    logic              slow;
    int                cyc;

    initial begin
        pix_valid = 1'b0;
        pix_data  = 16'h0;
        pix_sof   = 1'b0;
        pix_eol   = 1'b0;
        out_ready = 1'b1;
        slow      = 1'b0;
        cyc       = 0;
    end

    // sink; slow mode accepts one cycle in four so the buffer fills
    always @(posedge clk) begin
        cyc <= srst ? 0 : cyc + 1;
        if (!srst && out_valid && out_ready)
            got_q.push_back(out_data);
        out_ready <= !slow || (cyc % 4 == 0);
    end

    // raster source; frame stays inside the sensor limits
    task automatic send_frame(input int cols, input int rows);
        for (int r = 0; r < rows; r++)
            for (int c = 0; c < cols; c++) begin
                pix_valid <= 1'b1;
                pix_data  <= 16'(r * 64 + c * 8 + 1);
                pix_sof   <= (r == 0 && c == 0);
                pix_eol   <= (c == cols - 1);
                do @(posedge clk); while (pix_ready !== 1'b1);
            end
        // released data is scrambled so a stale word never looks valid
        pix_valid <= 1'b0;
        pix_sof   <= 1'b0;
        pix_eol   <= 1'b0;
        pix_data  <= ~pix_data;
    endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`include "pwgo_defs.svh"

module tb_top;
    logic              clk;
    logic              srst;
    logic [3:0]        reg_addr;
    logic [31:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [31:0]       reg_rdata;
    logic              pix_valid, pix_sof, pix_eol, pix_ready;
    logic              out_valid, out_ready, window_active;
    logic [`PIX_W-1:0] pix_data, out_data;
    logic [31:0]       rd_val;
    int                error_cnt;
    int                tests_run;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    pixel_window_gain_offset dut_u (
        .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pix_valid(pix_valid), .pix_data(pix_data), .pix_sof(pix_sof), .pix_eol(pix_eol),
        .pix_ready(pix_ready), .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready), .window_active(window_active)
    );

    pix_partner pm_u (
        .clk(clk), .srst(srst), .pix_ready(pix_ready), .out_valid(out_valid),
        .out_data(out_data), .pix_valid(pix_valid), .pix_data(pix_data),
        .pix_sof(pix_sof), .pix_eol(pix_eol), .out_ready(out_ready)
    );

    // ********
    // access tasks and comparison
    // ********
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // 6x4 frame; expected words from gain factor, offset and full scale
    task automatic run_frame(input int mul, input int off, input int full, input bit win);
        logic [31:0] exp_q[$];
        int          v;
        for (int r = 0; r < 4; r++)
            for (int c = 0; c < 6; c++) begin
                v = (r * 64 + c * 8 + 1) * mul + off;
                if (!win || (c >= 2 && c < 4 && r >= 2))
                    exp_q.push_back(32'(v > full ? full : v));
            end
        pm_u.got_q.delete();
        // a new gain reaches the factor one edge after the write
        @(posedge clk);
        pm_u.send_frame(6, 4);
        for (int i = 0; i < 80 && (out_valid === 1'b1 || i < 4); i++)
            @(posedge clk);
        chk("pixel count", 32'(exp_q.size()), 32'(pm_u.got_q.size()));
        foreach (exp_q[i])
            if (i < pm_u.got_q.size())
                chk("pixel value", exp_q[i], 32'(pm_u.got_q[i]));
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ********
    // test sequence
    // ********
    initial begin
        logic [31:0] dflt[12];
        logic [31:0] g_val[5];
        logic        g_col[5];
        logic        g_ok[5];
        logic [31:0] prev;
        dflt  = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h293, 32'h1EE, 32'hC0, 32'h8,
                  32'h0, 32'h0, 32'h0, 32'h0};
        g_val = '{32'hBF, 32'h300, 32'h301, 32'h280, 32'h281};
        g_col = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        g_ok  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        prev  = 32'hC0;
        srst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        error_cnt = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        // defaults, then one unmapped index
        for (int a = 0; a < 12; a++) begin
            reg_read(4'(a), rd_val);
            chk("reset value", dflt[a], rd_val);
        end
        // gain limits per variant; refused writes keep the old value
        for (int i = 0; i < 5; i++) begin
            reg_write(`REG_OUT_CONFIG, {31'h0, g_col[i]});
            reg_write(`REG_GAIN, g_val[i]);
            reg_read(`REG_STATUS, rd_val);
            chk("gain refusal flag", {30'h0, ~g_ok[i], 1'b0}, rd_val);
            if (g_ok[i])
                prev = g_val[i];
            reg_read(`REG_GAIN, rd_val);
            chk("gain value", prev, rd_val);
            reg_write(`REG_STATUS, 32'h2);
        end
        reg_read(`REG_STATUS, rd_val);
        chk("refusal flag cleared", 32'h0, rd_val);
        reg_write(`REG_OUT_CONFIG, 32'h0);
        reg_write(`REG_GAIN, 32'hC0);
        // window selection by format and mode
        reg_write(`REG_VIDEO_FORMAT, 32'h7);
        reg_read(`REG_STATUS, rd_val);
        chk("window on", 32'h1, rd_val);
        reg_write(`REG_VIDEO_MODE, 32'h1);
        reg_read(`REG_STATUS, rd_val);
        chk("window off by mode", 32'h0, rd_val);
        reg_write(`REG_VIDEO_MODE, 32'h0);
        reg_write(`REG_WIN_LEFT, 32'h2);
        reg_write(`REG_WIN_TOP, 32'h2);
        reg_write(`REG_WIN_WIDTH, 32'h2);
        reg_write(`REG_WIN_HEIGHT, 32'h2);
        run_frame(1, 0, 255, 1'b1);
        reg_read(`REG_POSITION, rd_val);
        chk("position after frame", 32'h0004_0000, rd_val);
        // window off: every pixel passes, the first frame with the sink stalling
        reg_write(`REG_VIDEO_FORMAT, 32'h0);
        pm_u.slow <= 1'b1;
        run_frame(1, 0, 255, 1'b0);
        pm_u.slow <= 1'b0;
        reg_write(`REG_GAIN, 32'h176);
        run_frame(2, 0, 255, 1'b0);
        reg_write(`REG_GAIN, 32'h1F3);
        run_frame(4, 0, 255, 1'b0);
        reg_write(`REG_GAIN, 32'hC0);
        reg_write(`REG_BRIGHTNESS, 32'hFF);
        reg_read(`REG_BRIGHTNESS, rd_val);
        chk("brightness top", 32'hFF, rd_val);
        reg_write(`REG_BRIGHTNESS, 32'h28);
        run_frame(1, 2, 255, 1'b0);
        // sixteen-bit then twelve-bit depth with unity gain
        reg_write(`REG_OUT_CONFIG, 32'h6);
        reg_write(`REG_BRIGHTNESS, 32'h5);
        run_frame(1, 5, 65535, 1'b0);
        reg_write(`REG_OUT_CONFIG, 32'h2);
        run_frame(1, 0, 4095, 1'b0);
        wrap_up;
    end

    // watchdog; the full sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up;
    end
endmodule
